// File: verilog/wsw_watchdog.sv
// watchdog timer with sleep entry and wake-up control, APB registers
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
//
// Operation
// - watchdog counts ticks of its own RC oscillator, also during sleep
// - time-out while running issues a full watchdog reset
// - time-out while asleep wakes without reset; timeout flag cleared
// - cleared enable configuration bit stops the watchdog from ever timing out
// - option assign and select bits route the shared scaler and set its ratio
// - clear-watchdog or sleep clears the count and the assigned postscaler
// - clear-watchdog leaves the scaler alone when assigned to timer zero, assignment left unchanged
// - sleep clears watchdog, clears powerdown, sets timeout, stops main oscillator
// - ports hold their driven state throughout sleep
// - master clear resets fully; time-out or enabled interrupt resumes
// - power-up sets powerdown flag; only a time-out clears timeout flag
// - only clock-free peripheral interrupts can wake from sleep
// - sleep prefetches the instruction at program counter plus one
// - wake needs the source enable; global enable does not matter
// - after interrupt wake run next instruction, then vector if enabled
// - enabled interrupt pending at sleep makes sleep a no-operation
// - interrupt during or after sleep: sleep completes, then wakes at once
// - crystal and low-power modes wait 1024 oscillator periods before running
// - servicing clears global enable, pushes return address, jumps to vector; this block only raises irq_service and gives irq_vector_addr
module wsw_watchdog #(
    parameter int WDT_PERIOD_TICKS = wsw_pkg::WDT_PERIOD_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdt_osc_pin,
    input wire logic timer_zero_pin,
    input wire logic master_clear_input_n,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic [wsw_pkg::PC_W-1:0] pc,
    input wire logic [wsw_pkg::IRQ_N-1:0] irq_flags,
    input wire logic [wsw_pkg::IRQ_N-1:0] irq_enables,
    input wire logic global_irq_enable,
    output logic watchdog_reset,
    output logic device_reset,
    output logic wake,
    output logic core_run,
    output logic main_osc_enable,
    output logic io_hold,
    output logic [wsw_pkg::PC_W-1:0] prefetch_addr,
    output logic prefetch_valid,
    output logic irq_service,
    output logic [wsw_pkg::PC_W-1:0] irq_vector_addr,
    output logic timer_zero_inc
);
    typedef struct packed {
        wsw_pkg::wsw_mode_type mode;
        logic [7:0] option_control;
        logic [7:0] configuration_word;
        logic timeout_flag;
        logic powerdown_flag;
        logic [wsw_pkg::WDT_CNT_W-1:0] wdt_count;
        logic wdt_ovf;
        logic osc_prev;
        logic t0_prev;
        logic [wsw_pkg::OST_CNT_W-1:0] ost_count;
        logic [31:0] prdata;
        logic pslverr;
        logic watchdog_reset;
        logic device_reset;
        logic wake;
        logic [wsw_pkg::PC_W-1:0] prefetch_addr;
        logic prefetch_valid;
        logic irq_service;
    } wsw_state_type;

    wsw_state_type s;
    wsw_state_type next_s;

    logic [2:0] pins_sync;
    logic osc_s;
    logic t0_s;
    logic master_clear_input_n_s;
    logic osc_rise;
    logic t0_rise;
    logic timeout;
    logic do_clear;
    logic wdt_en;
    logic assign_wdt;
    logic pending;
    logic wake_pending;
    logic apb_setup;
    logic apb_write;
    logic hit_status;
    logic hit_option;
    logic hit_config;
    logic [7:0] status_view;
    logic [wsw_pkg::WDT_CNT_W-1:0] wdt_last;
    logic [wsw_pkg::OST_CNT_W-1:0] ost_last;

    wsw_sync #(
        .W(3)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        // master clear enters inverted so the flops' reset value means released
        .din({!master_clear_input_n, timer_zero_pin, wdt_osc_pin}),
        .dout(pins_sync)
    );

    assign osc_s = pins_sync[0];
    assign t0_s = pins_sync[1];
    assign master_clear_input_n_s = !pins_sync[2];

    assign wdt_en = s.configuration_word[wsw_pkg::CFG_WATCHDOG_ENABLE_FUSE];
    assign assign_wdt = s.option_control[wsw_pkg::OPT_PSA];

    wsw_postscaler u_scaler (
        .clk(clk),
        .nrst(nrst),
        .wdt_tick(s.wdt_ovf),
        .t0_tick(t0_rise),
        .assign_wdt(assign_wdt),
        .ratio(s.option_control[wsw_pkg::OPT_PS_LSB +: 3]),
        .clear(do_clear),
        .wdt_out(timeout),
        .t0_out(timer_zero_inc)
    );

    assign wdt_last = wsw_pkg::WDT_CNT_W'(WDT_PERIOD_TICKS - 1);
    assign ost_last = wsw_pkg::OST_CNT_W'(wsw_pkg::OST_CYCLES - 1);

    // interrupt requests as seen by the wake and service logic
    assign pending = |(irq_flags & irq_enables);
    assign wake_pending = |(irq_flags & irq_enables & wsw_pkg::WAKE_CAPABLE);

    // register decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign hit_status = paddr == {wsw_pkg::IDX_STATUS, 2'b00};
    assign hit_option = paddr == {wsw_pkg::IDX_OPTION, 2'b00};
    assign hit_config = paddr == {wsw_pkg::IDX_CONFIG, 2'b00};

    always_comb begin
        status_view = 8'h00;
        status_view[wsw_pkg::ST_SLEEP] = s.mode == wsw_pkg::WSW_SLEEP;
        status_view[wsw_pkg::ST_OSC_START] = s.mode == wsw_pkg::WSW_OSC_START;
        status_view[wsw_pkg::ST_PD] = s.powerdown_flag;
        status_view[wsw_pkg::ST_TO] = s.timeout_flag;
    end

    always_comb begin
        next_s = s;
        next_s.wdt_ovf = 1'b0;
        next_s.watchdog_reset = 1'b0;
        next_s.wake = 1'b0;
        next_s.prefetch_valid = 1'b0;
        do_clear = 1'b0;

        osc_rise = osc_s && !s.osc_prev;
        t0_rise = t0_s && !s.t0_prev;
        next_s.osc_prev = osc_s;
        next_s.t0_prev = t0_s;

        // register reads are captured in the setup cycle
        if (apb_setup) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h0000_0000;
            if (hit_status) begin
                next_s.prdata = {24'h00_0000, status_view};
            end else if (hit_option) begin
                next_s.prdata = {24'h00_0000, s.option_control};
            end else if (hit_config) begin
                next_s.prdata = {24'h00_0000, s.configuration_word};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        if (apb_write) begin
            if (hit_option) begin
                next_s.option_control = pwdata[7:0];
            end
            if (hit_config) begin
                next_s.configuration_word = pwdata[7:0];
            end
        end

        case (s.mode)
            wsw_pkg::WSW_RUN: begin
                if (timeout && wdt_en) begin
                    // full reset of the block's control state
                    next_s.watchdog_reset = 1'b1;
                    next_s.timeout_flag = 1'b0;
                    next_s.option_control = wsw_pkg::OPTION_RST;
                    do_clear = 1'b1;
                end else begin
                    if (clear_watchdog_instr) begin
                        do_clear = 1'b1;
                    end
                    if (sleep_instr) begin
                        next_s.prefetch_valid = 1'b1;
                        next_s.prefetch_addr = pc + wsw_pkg::PC_W'(1);
                        if (!pending) begin
                            // real sleep; a pending request makes it a no-op
                            do_clear = 1'b1;
                            next_s.powerdown_flag = 1'b0;
                            next_s.timeout_flag = 1'b1;
                            next_s.mode = wsw_pkg::WSW_SLEEP;
                        end
                    end
                end
            end
            wsw_pkg::WSW_SLEEP: begin
                // a request arriving as sleep completes wakes at once
                if ((timeout && wdt_en) || wake_pending) begin
                    if (timeout && wdt_en) begin
                        next_s.timeout_flag = 1'b0;
                    end
                    next_s.ost_count = '0;
                    if (s.configuration_word[wsw_pkg::CFG_FOSC_LSB +: 2] == wsw_pkg::FOSC_RC) begin
                        next_s.mode = wsw_pkg::WSW_RUN;
                        next_s.wake = 1'b1;
                    end else begin
                        next_s.mode = wsw_pkg::WSW_OSC_START;
                    end
                end
            end
            wsw_pkg::WSW_OSC_START: begin
                if (s.ost_count == ost_last) begin
                    next_s.mode = wsw_pkg::WSW_RUN;
                    next_s.wake = 1'b1;
                end else begin
                    next_s.ost_count = s.ost_count + wsw_pkg::OST_CNT_W'(1);
                end
            end
            default: begin
                next_s.mode = wsw_pkg::WSW_RUN;
            end
        endcase

        // master clear: full reset, leaves sleep, flags kept
        next_s.device_reset = !master_clear_input_n_s;
        if (!master_clear_input_n_s) begin
            next_s.mode = wsw_pkg::WSW_RUN;
            next_s.option_control = wsw_pkg::OPTION_RST;
            next_s.ost_count = '0;
            next_s.wake = 1'b0;
            next_s.watchdog_reset = 1'b0;
            next_s.prefetch_valid = 1'b0;
            do_clear = 1'b1;
        end

        // watchdog count runs on its own ticks whether the core runs or sleeps
        if (do_clear || !wdt_en) begin
            next_s.wdt_count = '0;
        end else if (osc_rise) begin
            if (s.wdt_count == wdt_last) begin
                next_s.wdt_count = '0;
                next_s.wdt_ovf = 1'b1;
            end else begin
                next_s.wdt_count = s.wdt_count + wsw_pkg::WDT_CNT_W'(1);
            end
        end
        if (do_clear) begin
            next_s.wdt_ovf = 1'b0;
        end

        // core vectors only while running with global enable set
        next_s.irq_service = (next_s.mode == wsw_pkg::WSW_RUN) && master_clear_input_n_s
                             && global_irq_enable && pending;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.mode <= wsw_pkg::WSW_RUN;
            s.option_control <= wsw_pkg::OPTION_RST;
            s.configuration_word <= wsw_pkg::CONFIG_RST;
            s.timeout_flag <= 1'b1;
            s.powerdown_flag <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = s.pslverr;
    assign watchdog_reset = s.watchdog_reset;
    assign device_reset = s.device_reset;
    assign wake = s.wake;
    assign core_run = s.mode == wsw_pkg::WSW_RUN;
    assign main_osc_enable = s.mode != wsw_pkg::WSW_SLEEP;
    assign io_hold = s.mode != wsw_pkg::WSW_RUN;
    assign prefetch_addr = s.prefetch_addr;
    assign prefetch_valid = s.prefetch_valid;
    assign irq_service = s.irq_service;
    assign irq_vector_addr = wsw_pkg::VECTOR_ADDR;
endmodule

// File: verilog/wsw_pkg.sv
// constants and types shared by the watchdog, sleep and wake block
package wsw_pkg;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_STATUS = 14'h0003;
    localparam logic [13:0] IDX_OPTION = 14'h0081;
    localparam logic [13:0] IDX_CONFIG = 14'h2007;
    // option_control fields
    localparam int OPT_PSA = 3;
    localparam int OPT_PS_LSB = 0;
    // configuration_word fields
    localparam int CFG_WATCHDOG_ENABLE_FUSE = 2;
    localparam int CFG_FOSC_LSB = 0;
    localparam logic [1:0] FOSC_RC = 2'h3;
    // status fields
    localparam int ST_SLEEP = 0;
    localparam int ST_OSC_START = 1;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    // values after reset
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [7:0] CONFIG_RST = 8'hff;
    // oscillator start-up delay: 1024 main oscillator periods
    localparam int OST_TOSC = 1024;
    localparam int CLK_PER_TOSC = 1;
    localparam int OST_CYCLES = OST_TOSC * CLK_PER_TOSC;
    localparam int OST_CNT_W = 11;
    // watchdog count, in ticks of its own oscillator
    localparam int WDT_CNT_W = 12;
    localparam int WDT_PERIOD_DEF = 256;
    // interrupt lines and which of them run without on-chip clocks
    localparam int IRQ_N = 8;
    localparam logic [7:0] WAKE_CAPABLE = 8'h7f;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    localparam int PC_W = 13;

    typedef enum logic [1:0] {
        WSW_RUN,
        WSW_SLEEP,
        WSW_OSC_START
    } wsw_mode_type;
endpackage

// File: verilog/wsw_sync.sv
// two-flop synchroniser for pins outside the clock domain
`timescale 1ns/10ps
module wsw_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } wsw_sync_state_type;

    wsw_sync_state_type s;
    wsw_sync_state_type next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < W; i++) begin
            next_s.s1[i] = din[i];
            next_s.s2[i] = s.s1[i];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.s2;
endmodule

// File: verilog/wsw_postscaler.sv
// 8-bit scaler shared between watchdog postscale and timer-zero prescale
`timescale 1ns/10ps
module wsw_postscaler (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wdt_tick,
    input wire logic t0_tick,
    input wire logic assign_wdt,
    input wire logic [2:0] ratio,
    input wire logic clear,
    output logic wdt_out,
    output logic t0_out
);
    typedef struct packed {
        logic [7:0] count;
        logic wdt_out;
        logic t0_out;
    } wsw_ps_state_type;

    wsw_ps_state_type s;
    wsw_ps_state_type next_s;
    logic src;
    logic [7:0] last;

    always_comb begin
        next_s = s;
        next_s.wdt_out = 1'b0;
        next_s.t0_out = 1'b0;
        src = assign_wdt ? wdt_tick : t0_tick;
        // watchdog ratio 1:2^n, timer-zero ratio 1:2^(n+1)
        last = assign_wdt ? 8'((9'h001 << ratio) - 9'h001)
                          : 8'((9'h002 << ratio) - 9'h001);
        if (clear && assign_wdt) begin
            next_s.count = 8'h00;
        end else if (src) begin
            if (s.count == last) begin
                next_s.count = 8'h00;
                next_s.wdt_out = assign_wdt;
                next_s.t0_out = !assign_wdt;
            end else begin
                next_s.count = s.count + 8'h01;
            end
        end
        // the unassigned side bypasses the scaler
        if (!assign_wdt) begin
            next_s.wdt_out = wdt_tick;
        end else begin
            next_s.t0_out = t0_tick;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wdt_out = s.wdt_out;
    assign t0_out = s.t0_out;
endmodule

// File: verif/wsw_watchdog_sva.sv
// assertions on the watchdog, sleep and wake ports
`timescale 1ns/10ps
module wsw_watchdog_sva #(
    parameter int WDT_PERIOD_TICKS = wsw_pkg::WDT_PERIOD_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sleep_instr,
    input wire logic [wsw_pkg::PC_W-1:0] pc,
    input wire logic [wsw_pkg::IRQ_N-1:0] irq_flags,
    input wire logic [wsw_pkg::IRQ_N-1:0] irq_enables,
    input wire logic global_irq_enable,
    input wire logic master_clear_input_n,
    input wire logic device_reset,
    input wire logic wake,
    input wire logic core_run,
    input wire logic main_osc_enable,
    input wire logic io_hold,
    input wire logic [wsw_pkg::PC_W-1:0] prefetch_addr,
    input wire logic prefetch_valid,
    input wire logic irq_service,
    input wire logic watchdog_reset
);
    wire logic [7:0] pend_en = irq_flags & irq_enables;
    wire logic [7:0] pend_wake = pend_en & wsw_pkg::WAKE_CAPABLE;
    logic [10:0] ost_cnt;
    // length of the current oscillator start-up stretch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            ost_cnt <= 11'h000;
        else if (main_osc_enable && !core_run)
            ost_cnt <= ost_cnt + 11'h001;
        else
            ost_cnt <= 11'h000;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_PREFETCH: assert property (core_run && sleep_instr |=> prefetch_valid
        && prefetch_addr == $past(pc) + 13'h0001) else $error("prefetch address wrong");
    AST_SLEEP_ENTRY: assert property (core_run && sleep_instr && pend_en == 8'h00
        |=> !main_osc_enable || watchdog_reset || device_reset) else $error("no sleep");
    AST_NOOP: assert property (core_run && sleep_instr && pend_en != 8'h00
        |=> main_osc_enable && core_run) else $error("pending sleep not a no-op");
    AST_HOLD: assert property (!main_osc_enable |-> io_hold && !core_run)
        else $error("ports not held in sleep");
    AST_MASTER_CLEAR_INPUT: assert property (!master_clear_input_n [*4] |-> device_reset)
        else $error("master clear ignored");
    AST_IRQ_WAKE: assert property (!main_osc_enable && pend_wake != 8'h00
        |=> main_osc_enable) else $error("enabled interrupt did not wake");
    AST_WAKE_RUN: assert property (wake |-> core_run && main_osc_enable && !io_hold)
        else $error("wake without running core");
    AST_SERVICE: assert property (irq_service |-> $past(global_irq_enable))
        else $error("service without global enable");
    AST_OST: assert property ($rose(core_run) && ost_cnt != 11'h000
        |-> ost_cnt inside {[11'd1023:11'd1025]}) else $error("start-up length wrong");
    COV_WAKE: cover property (wake);
    COV_WRST: cover property (watchdog_reset);
    COV_OST: cover property ($rose(core_run) && ost_cnt != 11'h000);
endmodule
bind wsw_watchdog wsw_watchdog_sva #(.WDT_PERIOD_TICKS(WDT_PERIOD_TICKS)) u_wsw_watchdog_sva (
    .clk, .nrst, .sleep_instr, .pc, .irq_flags, .irq_enables, .global_irq_enable,
    .master_clear_input_n, .device_reset, .wake, .core_run, .main_osc_enable, .io_hold,
    .prefetch_addr, .prefetch_valid, .irq_service, .watchdog_reset
);

// File: verif/wsw_core_model.sv
// behavioural core issuing instruction pulses and master clear
`timescale 1ns/10ps
module wsw_core_model (
    input wire logic clk,
    output logic clear_watchdog_instr,
    output logic sleep_instr,
    output logic [12:0] pc,
    output logic master_clear_input_n
);
    initial begin
        clear_watchdog_instr = 1'b0;
        sleep_instr = 1'b0;
        pc = 13'h0000;
        master_clear_input_n = 1'b1;
    end
    task automatic issue(input logic is_sleep, input logic [12:0] addr);
        @(posedge clk);
        sleep_instr <= is_sleep;
        clear_watchdog_instr <= !is_sleep;
        pc <= addr;
        @(posedge clk);
        sleep_instr <= 1'b0;
        clear_watchdog_instr <= 1'b0;
    endtask
    // only lowered while the core is awake
    task automatic set_master_clear_input(input logic v);
        @(posedge clk);
        master_clear_input_n <= v;
    endtask
endmodule

// File: verif/wsw_watchdog_test.sv
// self-checking bench for the watchdog, sleep and wake block
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %0h seen %0h", n, e, a); end end
module wsw_watchdog_test;
    localparam logic [15:0] A_ST = 16'h000c;
    localparam logic [15:0] A_OP = 16'h0204;
    localparam logic [15:0] A_CF = 16'h801c;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wdt_osc_pin = 1'b0;
    logic timer_zero_pin = 1'b0, global_irq_enable = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] irq_flags = 8'h00, irq_enables = 8'h00;
    logic pready, pslverr, er, watchdog_reset, device_reset, wake, core_run, main_osc_enable;
    logic io_hold, prefetch_valid, irq_service, clear_watchdog_instr, sleep_instr;
    logic master_clear_input_n;
    logic [12:0] pc, prefetch_addr, irq_vector_addr;
    int mismatches = 0, check_count = 0, n_wake = 0, n_wrst = 0, w0, r0, n;
    wsw_watchdog #(.WDT_PERIOD_TICKS(4)) u_wsw_watchdog (.clk, .nrst, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .wdt_osc_pin,
        .timer_zero_pin, .master_clear_input_n, .clear_watchdog_instr, .sleep_instr, .pc,
        .irq_flags, .irq_enables, .global_irq_enable, .watchdog_reset, .device_reset,
        .wake, .core_run, .main_osc_enable, .io_hold, .prefetch_addr, .prefetch_valid,
        .irq_service, .irq_vector_addr, .timer_zero_inc());
    wsw_core_model u_wsw_core_model (.clk, .clear_watchdog_instr, .sleep_instr, .pc,
        .master_clear_input_n);
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wake === 1'b1) n_wake++;
        if (watchdog_reset === 1'b1) n_wrst++;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            repeat (3) @(posedge clk);
            wdt_osc_pin <= 1'b1;
            repeat (3) @(posedge clk);
            wdt_osc_pin <= 1'b0;
        end
    endtask
    task automatic t_regs;
        apb(1'b0, A_ST, 32'h0);
        `CHK("status", 32'h18, rd)
        apb(1'b1, A_ST, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        `CHK("status ro", 32'h18, rd)
        apb(1'b0, 16'h0100, 32'h0);
        `CHK("unmapped", 1'b1, er)
        apb(1'b1, A_OP, 32'h08);
        apb(1'b0, A_OP, 32'h0);
        `CHK("option", 32'h08, rd)
        $display("t_regs done");
    endtask
    task automatic t_noop;
        irq_flags <= 8'h01;
        irq_enables <= 8'h01;
        u_wsw_core_model.issue(1'b1, 13'h0040);
        @(negedge clk);
        `CHK("noop run", 1'b1, core_run)
        apb(1'b0, A_ST, 32'h0);
        `CHK("noop status", 32'h18, rd)
        irq_flags <= 8'h00;
        $display("t_noop done");
    endtask
    task automatic t_sleep_irq;
        w0 = n_wake;
        u_wsw_core_model.issue(1'b1, 13'h0100);
        irq_flags <= 8'h80;
        irq_enables <= 8'h80;
        @(negedge clk);
        `CHK("prefetch", 13'h0101, prefetch_addr)
        repeat (5) @(negedge clk);
        `CHK("clocked irq", 1'b0, main_osc_enable)
        `CHK("io hold", 1'b1, io_hold)
        apb(1'b0, A_ST, 32'h0);
        `CHK("sleep status", 32'h11, rd)
        irq_flags <= 8'h82;
        irq_enables <= 8'h82;
        repeat (4) @(negedge clk);
        `CHK("irq wake", w0 + 1, n_wake)
        `CHK("inline", 1'b0, irq_service)
        @(posedge clk);
        global_irq_enable <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK("vector", 1'b1, irq_service)
        `CHK("vector addr", 13'h0004, irq_vector_addr)
        @(posedge clk);
        irq_flags <= 8'h00;
        global_irq_enable <= 1'b0;
        $display("t_sleep_irq done");
    endtask
    task automatic t_wdt;
        apb(1'b1, A_OP, 32'h09);
        r0 = n_wrst;
        u_wsw_core_model.issue(1'b0, 13'h0);
        tick(7);
        u_wsw_core_model.issue(1'b0, 13'h0);
        tick(7);
        repeat (10) @(posedge clk);
        `CHK("cleared", r0, n_wrst)
        tick(2);
        repeat (10) @(posedge clk);
        `CHK("wdt reset", r0 + 1, n_wrst)
        apb(1'b0, A_ST, 32'h0);
        `CHK("timeout flag", 32'h00, rd)
        $display("t_wdt done");
    endtask
    task automatic t_wdt_sleep;
        apb(1'b1, A_OP, 32'h08);
        w0 = n_wake;
        r0 = n_wrst;
        u_wsw_core_model.issue(1'b1, 13'h0200);
        tick(5);
        repeat (10) @(posedge clk);
        `CHK("wdt wake", w0 + 1, n_wake)
        `CHK("no reset", r0, n_wrst)
        apb(1'b0, A_ST, 32'h0);
        `CHK("wake status", 32'h00, rd)
        apb(1'b1, A_CF, 32'hfb);
        tick(12);
        repeat (10) @(posedge clk);
        `CHK("fuse off", r0, n_wrst)
        $display("t_wdt_sleep done");
    endtask
    task automatic t_ost;
        apb(1'b1, A_CF, 32'hf8);
        w0 = n_wake;
        u_wsw_core_model.issue(1'b1, 13'h0300);
        repeat (3) @(posedge clk);
        irq_flags <= 8'h02;
        n = 0;
        while (n_wake == w0 && n < 1200) begin
            @(posedge clk);
            n++;
        end
        `CHK("start-up", 1'b1, n >= 1024 && n <= 1028)
        irq_flags <= 8'h00;
        $display("t_ost done");
    endtask
    task automatic t_master_clear_input;
        u_wsw_core_model.set_master_clear_input(1'b0);
        repeat (5) @(negedge clk);
        `CHK("master_clear_input", 1'b1, device_reset)
        u_wsw_core_model.set_master_clear_input(1'b1);
        repeat (5) @(negedge clk);
        `CHK("master_clear_input off", 1'b0, device_reset)
        apb(1'b0, A_OP, 32'h0);
        `CHK("option reset", 32'hff, rd)
        $display("t_master_clear_input done");
    endtask
    initial begin
        repeat (10000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_noop;
        t_sleep_irq;
        t_wdt;
        t_wdt_sleep;
        t_ost;
        t_master_clear_input;
        tally_and_finish;
    end
endmodule
